/* File: core/phy_basic_status_and_id_regs.sv */
/*
  basic status register and the two identifier registers of an ethernet
  transceiver, with an event status/mask pair, behind an axi4-lite slave.
  assumes link, negotiation, remote fault and jabber inputs are synchronous
  to clock_in; one outstanding write and one read at a time.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module phy_basic_status_and_id_regs
  import phy_status_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [org_id_w-1:0] org_id = 24'h5a5a5a,
  parameter logic [model_w-1:0] model_number = 6'h15,
  parameter logic [revision_w-1:0] revision_number = 4'h1,
  parameter bit id_zero = 1'b0
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic link_up_in,
  input wire logic negotiation_done_in,
  input wire logic remote_fault_in,
  input wire logic jabber_in,
  input wire logic [addr_w-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [addr_w-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic irq_out
);

  typedef struct packed {
    logic aw_held;
    logic [addr_w-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic negotiation_done;
    logic remote_fault;
    logic link_up_latched;
    logic jabber_seen;
    logic [ev_w-1:0] ev_status;
    logic [ev_w-1:0] ev_mask;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------
  // read-only images
  // ----------------------------------------
  logic [15:0] status_word;
  logic [15:0] id_high;
  logic [15:0] id_low;
  logic [31:0] full_id;

  always_comb begin
    status_word = 16'h0000; // reserved bits stay 0
    status_word[pos_fast_full_duplex_able] = 1'b1;
    status_word[pos_fast_half_duplex_able] = 1'b1;
    status_word[pos_slow_full_duplex_able] = 1'b1;
    status_word[pos_slow_half_duplex_able] = 1'b1;
    status_word[pos_gigabit_status_present] = 1'b1;
    status_word[pos_short_frame_accept] = 1'b1;
    status_word[pos_negotiation_done] = st.negotiation_done;
    status_word[pos_remote_fault] = st.remote_fault;
    status_word[pos_negotiation_capable] = 1'b1;
    status_word[pos_link_up_latched] = st.link_up_latched;
    status_word[pos_jabber_seen] = st.jabber_seen;
    status_word[pos_extended_set_present] = 1'b1;
  end

  // org id bit n (1 = msb) sits at vector index 24-n, so bits 3..18 are [21:6]
  assign full_id = id_zero ? 32'h00000000 :
    {org_id[21:0], model_number, revision_number};
  assign id_high = full_id[31:16];
  assign id_low = full_id[15:0];

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic rd_fire;
  logic rd_status;
  logic rd_events;
  logic wr_go;
  logic [4:0] rd_idx;
  logic [4:0] wr_idx;
  logic rd_ok;
  logic [31:0] rd_word;

  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_idx = s_axi_araddr_in[6:2];
  assign wr_idx = st.aw_addr[6:2];
  assign rd_status = rd_fire && rd_ok && rd_idx == idx_basic_link_status;
  assign rd_events = rd_fire && rd_ok && rd_idx == idx_event_status;
  assign wr_go = st.aw_held && st.w_held && !st.bvalid;

  always_comb begin
    rd_ok = (s_axi_araddr_in[1:0] == 2'h0) && (s_axi_araddr_in[addr_w-1:7] == '0);
    rd_word = 32'h00000000;
    case (rd_idx)
      idx_basic_link_status: rd_word = {16'h0000, status_word};
      idx_vendor_identifier_high: rd_word = {16'h0000, id_high};
      idx_vendor_identifier_low: rd_word = {16'h0000, id_low};
      idx_event_mask: rd_word = {29'h0, st.ev_mask};
      idx_event_status: rd_word = {29'h0, st.ev_status};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    logic [ev_w-1:0] ev_set;
    ev_set = '0;
    next_st = st;

    // write path: address and data taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = resp_okay;
      // status and id registers swallow writes silently
      if (wr_idx == idx_event_mask && st.aw_addr[addr_w-1:7] == '0 && st.aw_addr[1:0] == 2'h0) begin
        if (st.w_strb[0]) begin
          next_st.ev_mask = st.w_data[ev_w-1:0];
        end
      end else if (!(wr_idx inside {idx_basic_link_status, idx_vendor_identifier_high,
                     idx_vendor_identifier_low, idx_event_status}) ||
                   st.aw_addr[addr_w-1:7] != '0 || st.aw_addr[1:0] != 2'h0) begin
        next_st.bresp = resp_slverr;
      end
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    // read path
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? resp_okay : resp_slverr;
    end else if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end

    // live status: events win over the clear-on-read in the same cycle
    next_st.negotiation_done = negotiation_done_in;
    if (rd_status) begin
      next_st.remote_fault = 1'b0;
      next_st.jabber_seen = 1'b0;
      next_st.link_up_latched = link_up_in;
    end
    if (remote_fault_in) begin
      next_st.remote_fault = 1'b1;
    end
    if (jabber_in) begin
      next_st.jabber_seen = 1'b1;
    end
    if (!link_up_in) begin
      next_st.link_up_latched = 1'b0;
    end else if (!st.link_up_latched && !rd_status) begin
      next_st.link_up_latched = 1'b0;
    end

    // sticky events; read clears them, a fresh event survives the read
    ev_set[ev_remote_fault] = remote_fault_in && !st.remote_fault;
    ev_set[ev_jabber] = jabber_in && !st.jabber_seen;
    ev_set[ev_link_loss] = !link_up_in && st.link_up_latched;
    if (rd_events) begin
      next_st.ev_status = ev_set;
    end else begin
      next_st.ev_status = st.ev_status | ev_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st <= '0; // negotiation_done and latched flags reset to 0
      st.ev_mask <= mask_reset;
      st.bresp <= resp_okay;
      st.rresp <= resp_okay;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready_out = !st.aw_held && !st.bvalid;
  assign s_axi_wready_out = !st.w_held && !st.bvalid;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  // a read waits for the previous answer to drain, one at a time
  assign s_axi_arready_out = !st.rvalid;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign irq_out = |(st.ev_status & st.ev_mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // patterns rebuilt from the field positions, so a moved bit moves them too and is not caught here
  localparam logic [15:0] fixed_bits = 16'((1 << pos_fast_full_duplex_able) | (1 << pos_fast_half_duplex_able) |
    (1 << pos_slow_full_duplex_able) | (1 << pos_slow_half_duplex_able) |
    (1 << pos_gigabit_status_present) | (1 << pos_short_frame_accept) |
    (1 << pos_negotiation_capable) | (1 << pos_extended_set_present));
  localparam logic [15:0] live_bits = 16'((1 << pos_negotiation_done) | (1 << pos_remote_fault) |
    (1 << pos_link_up_latched) | (1 << pos_jabber_seen));

  logic rd_id_high;
  logic rd_id_low;
  logic wr_ro;

  assign rd_id_high = rd_fire && rd_ok && rd_idx == idx_vendor_identifier_high;
  assign rd_id_low = rd_fire && rd_ok && rd_idx == idx_vendor_identifier_low;
  assign wr_ro = wr_go && st.aw_addr[1:0] == 2'h0 && st.aw_addr[addr_w-1:7] == '0 &&
    (wr_idx inside {idx_basic_link_status, idx_vendor_identifier_high, idx_vendor_identifier_low});

  sequence status_read_s;
    rd_status && !remote_fault_in && !jabber_in;
  endsequence

  sequence answer_s;
    s_axi_rvalid_out;
  endsequence

  sequence link_drop_s;
    !link_up_in ##1 (link_up_in && !rd_status)[*2];
  endsequence

  a_fast_modes_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[14:13] == 2'b11 && !s_axi_rdata_out[15])
    else $error("fast duplex bits wrong");

  a_slow_modes_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[12:11] == 2'b11 && s_axi_rdata_out[10:9] == 2'b00)
    else $error("slow duplex bits wrong");

  a_gigabit_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[8] && !s_axi_rdata_out[7])
    else $error("gigabit status flag wrong");

  a_short_frame_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[pos_short_frame_accept])
    else $error("short frame flag wrong");

  a_negotiation_track: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[pos_negotiation_done] == $past(st.negotiation_done))
    else $error("negotiation done not reported");

  // no disable here: this one must look at the edges while reset is high
  a_flags_reset: assert property (@(posedge clock_in)
    sys_rst_in |=> !st.negotiation_done && !st.remote_fault && !st.jabber_seen && !st.link_up_latched)
    else $error("status flags not cleared by reset");

  a_fault_clear_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    status_read_s |=> !st.remote_fault)
    else $error("remote fault not cleared by read");

  a_fault_sticky: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    remote_fault_in |=> st.remote_fault ##1 (st.remote_fault || $past(rd_status)))
    else $error("remote fault not sticky");

  a_negotiation_capable: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[pos_negotiation_capable])
    else $error("negotiation capable flag wrong");

  a_link_latch_low: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    link_drop_s |-> !st.link_up_latched)
    else $error("link status did not latch low");

  a_link_reload: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> st.link_up_latched == $past(link_up_in))
    else $error("link status not reloaded by read");

  a_jabber_sets: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    jabber_in |=> st.jabber_seen)
    else $error("jabber not latched");

  a_jabber_clear_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    status_read_s |=> !st.jabber_seen)
    else $error("jabber not cleared by read");

  a_extended_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> s_axi_rdata_out[pos_extended_set_present])
    else $error("extended set flag wrong");

  a_full_id: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_high |=> id_zero || {s_axi_rdata_out[15:0], id_low} == {org_id[21:0], model_number, revision_number})
    else $error("identifier pair wrong");

  a_org_top_dropped: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_high |=> id_zero || s_axi_rdata_out[15:14] == org_id[21:20])
    else $error("organization id top bits misplaced");

  a_id_high_layout: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_high |=> answer_s and (id_zero || s_axi_rdata_out == {16'h0000, org_id[21:6]}))
    else $error("identifier high layout wrong");

  a_id_layout: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_low |=> answer_s and (id_zero || s_axi_rdata_out[15:10] == org_id[5:0]))
    else $error("identifier low layout wrong");

  a_model_field: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_low |=> id_zero || s_axi_rdata_out[9:4] == model_number)
    else $error("model number field wrong");

  a_revision_field: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_low |=> id_zero || s_axi_rdata_out[3:0] == revision_number)
    else $error("revision number field wrong");

  a_id_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_id_high || rd_id_low |=> !id_zero || s_axi_rdata_out == 32'h00000000)
    else $error("zero identifier not returned");

  a_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_status |=> (s_axi_rdata_out[15:0] & ~(fixed_bits | live_bits)) == 16'h0000 &&
      s_axi_rdata_out[31:16] == 16'h0000 && (s_axi_rdata_out[15:0] & fixed_bits) == fixed_bits)
    else $error("reserved status bits not zero");

  a_status_nowrite: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_ro |=> $stable(st.ev_mask) && s_axi_bvalid_out && s_axi_bresp_out == resp_okay)
    else $error("read-only write took effect");

endmodule

`default_nettype wire

/* File: core/phy_status_pkg.sv */
/*
  package for the basic status and identifier register bank: offsets,
  field positions, reset values and the bus response codes.
  assumes a 32-bit axi4-lite register bus, one register per aligned word.
*/
package phy_status_pkg;

  // ----------------------------------------
  // register indices and bus address width
  // ----------------------------------------
  localparam logic [4:0] idx_basic_link_status = 5'h01;
  localparam logic [4:0] idx_vendor_identifier_high = 5'h02;
  localparam logic [4:0] idx_vendor_identifier_low = 5'h03;
  localparam logic [4:0] idx_event_mask = 5'h10;
  localparam logic [4:0] idx_event_status = 5'h11;
  localparam int addr_w = 8;

  // ----------------------------------------
  // status register bit positions
  // ----------------------------------------
  localparam int pos_fast_full_duplex_able = 14;
  localparam int pos_fast_half_duplex_able = 13;
  localparam int pos_slow_full_duplex_able = 12;
  localparam int pos_slow_half_duplex_able = 11;
  localparam int pos_gigabit_status_present = 8;
  localparam int pos_short_frame_accept = 6;
  localparam int pos_negotiation_done = 5;
  localparam int pos_remote_fault = 4;
  localparam int pos_negotiation_capable = 3;
  localparam int pos_link_up_latched = 2;
  localparam int pos_jabber_seen = 1;
  localparam int pos_extended_set_present = 0;
  localparam int ext_status_addr = 32'h0000000f;

  // ----------------------------------------
  // identifier layout
  // ----------------------------------------
  localparam int org_id_w = 24;
  localparam int model_w = 6;
  localparam int revision_w = 4;
  localparam int pos_org_id_lower = 10;
  localparam int pos_model = 4;
  localparam int pos_revision = 0;

  // ----------------------------------------
  // event status / mask bits
  // ----------------------------------------
  localparam int ev_w = 3;
  localparam int ev_remote_fault = 0;
  localparam int ev_jabber = 1;
  localparam int ev_link_loss = 2;
  localparam logic [ev_w-1:0] mask_reset = 3'h0;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

endpackage

/* File: tb/phy_basic_status_and_id_regs_test.sv */
/*
  self-checking bench for the basic status and identifier register bank.
  assumes the bench alone drives every port of the bank; no other model.
*/
`timescale 1ns/1ps
`default_nettype none

module phy_basic_status_and_id_regs_test;
  import phy_status_pkg::*;

  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  // identity values are arbitrary
  localparam logic [org_id_w-1:0] org_val = 24'h5a5a5a;
  localparam logic [model_w-1:0] model_val = 6'h15;
  localparam logic [revision_w-1:0] rev_val = 4'h1;
  localparam logic [7:0] a_stat = {1'b0, idx_basic_link_status, 2'b00};
  localparam logic [7:0] a_idh = {1'b0, idx_vendor_identifier_high, 2'b00};
  localparam logic [7:0] a_idl = {1'b0, idx_vendor_identifier_low, 2'b00};
  localparam logic [7:0] a_mask = {1'b0, idx_event_mask, 2'b00};
  localparam logic [7:0] a_evst = {1'b0, idx_event_status, 2'b00};
  localparam logic [31:0] st_fixed = (32'h1 << pos_fast_full_duplex_able) | (32'h1 << pos_fast_half_duplex_able)
    | (32'h1 << pos_slow_full_duplex_able) | (32'h1 << pos_slow_half_duplex_able)
    | (32'h1 << pos_gigabit_status_present) | (32'h1 << pos_short_frame_accept)
    | (32'h1 << pos_negotiation_capable) | (32'h1 << pos_extended_set_present);
  localparam logic [31:0] bit_link = 32'h1 << pos_link_up_latched;
  localparam logic [31:0] bit_neg = 32'h1 << pos_negotiation_done;

  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic link_up_in = 1'b0, neg_in = 1'b0, rf_in = 1'b0, jab_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  phy_basic_status_and_id_regs #(.org_id(org_val), .model_number(model_val), .revision_number(rev_val),
    .id_zero(1'b0)) dut_u (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .link_up_in(link_up_in), .negotiation_done_in(neg_in),
    .remote_fault_in(rf_in), .jabber_in(jab_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .irq_out(irq));

  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // handshakes are judged at the falling edge, so the following rising edge is the transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
    logic ta, tw, tb;
    @(posedge clock_in);
    awaddr <= a; wdata <= dv; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clock_in);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      rv = bresp;
      @(posedge clock_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    logic ta, tr;
    @(posedge clock_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clock_in);
      ta = arvalid & arready;
      tr = rvalid & rready;
      dv = rdata;
      rv = rresp;
      @(posedge clock_in);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    check(what, d, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_and_link;
    @(posedge clock_in) link_up_in <= 1'b1;
    rd_check("status after reset", a_stat, st_fixed);
    rd_check("status link second read", a_stat, st_fixed | bit_link);
  endtask

  task automatic t_ident;
    rd(a_idh, d, r);
    check("id high", d, {16'h0, org_val[21:6]});
    check("id high resp", {30'h0, r}, {30'h0, resp_okay});
    rd_check("id low", a_idl, {16'h0, org_val[5:0], model_val, rev_val});
  endtask

  task automatic t_sticky;
    logic [31:0] base;
    base = st_fixed | bit_link | bit_neg;
    @(posedge clock_in) neg_in <= 1'b1;
    rd_check("negotiation done", a_stat, base);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      if (k == 0) rf_in <= 1'b1;
      else jab_in <= 1'b1;
      @(posedge clock_in);
      rf_in <= 1'b0;
      jab_in <= 1'b0;
      rd_check("flag set", a_stat, base | (32'h1 << (k == 0 ? pos_remote_fault : pos_jabber_seen)));
      rd_check("flag cleared", a_stat, base);
    end
    // a single-cycle drop must be caught even though the link is back up
    @(posedge clock_in) link_up_in <= 1'b0;
    @(posedge clock_in) link_up_in <= 1'b1;
    rd_check("link latched low", a_stat, st_fixed | bit_neg);
    rd_check("link current", a_stat, base);
  endtask

  task automatic t_writes;
    wr(a_stat, 32'hffffffff, r);
    check("status write resp", {30'h0, r}, {30'h0, resp_okay});
    wr(a_idh, 32'h0, r);
    check("id write resp", {30'h0, r}, {30'h0, resp_okay});
    rd_check("status after write", a_stat, st_fixed | bit_link | bit_neg);
    rd_check("id high after write", a_idh, {16'h0, org_val[21:6]});
    rd(8'h20, d, r);
    check("unmapped rdata", d, 32'h0);
    check("unmapped rresp", {30'h0, r}, {30'h0, resp_slverr});
  endtask

  task automatic t_irq;
    rd(a_evst, d, r);
    rd_check("events drained", a_evst, 32'h0);
    @(posedge clock_in) jab_in <= 1'b1;
    @(posedge clock_in) jab_in <= 1'b0;
    @(negedge clock_in) check("irq masked", {31'h0, irq}, 32'h0);
    wr(a_mask, 32'h7, r);
    check("mask write resp", {30'h0, r}, {30'h0, resp_okay});
    rd_check("mask readback", a_mask, 32'h7);
    @(negedge clock_in) check("irq raised", {31'h0, irq}, 32'h1);
    rd_check("event status", a_evst, 32'h1 << ev_jabber);
    repeat (2) @(posedge clock_in);
    @(negedge clock_in) check("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(negedge clock_in) check("irq after reset", {31'h0, irq}, 32'h0);
    check("ready after reset", {29'h0, awready, wready, arready}, 32'h7);
    check("valid after reset", {30'h0, bvalid, rvalid}, 32'h0);
    t_reset_and_link();
    t_ident();
    t_sticky();
    t_writes();
    t_irq();
    complete_run();
  end
endmodule

`default_nettype wire
